/* core/burst_sram_pkg.sv */
// constants, types and pin bundle of the burst-of-two sram read port
// assumes one system clock that samples every link pin and link clock
`default_nettype none

package burst_sram_pkg;

    localparam int DATA_W        = 18;
    localparam int ADDR_W        = 18;
    localparam int DEPTH         = 262144;
    localparam int WORDS         = 2;
    localparam int LANES         = 2;
    localparam int LANE_W        = 9;
    localparam int BUF_DEPTH     = 2;
    localparam int CLK_PERIOD_NS = 8;
    // time allowed for the strap pins to pass the synchroniser
    localparam int STRAP_SETTLE_NS  = 24;
    localparam int STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [DATA_W-1:0] Q_RESET   = 18'h0_0000;
    localparam logic [1:0]        STRAP_CNT_RESET = 2'h0;

    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_LO   = 2'b01,
        OUT_HI   = 2'b10
    } out_state_e;

    typedef struct packed {
        logic              k;
        logic              k_n;
        logic              c;
        logic              c_n;
        logic              rps_n;
        logic              wps_n;
        logic [LANES-1:0]  bws_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d;
    } pins_s;

    localparam pins_s PINS_RESET = '{k: 1'b0, k_n: 1'b0, c: 1'b1, c_n: 1'b1,
                                    rps_n: 1'b1, wps_n: 1'b1, bws_n: 2'h3,
                                    addr: 18'h0_0000, d: 18'h0_0000};

endpackage : burst_sram_pkg

`default_nettype wire

/* core/burst_buf_if.sv */
// valid/ready carrier between the read pipeline and its two-entry buffer
// assumes both sides run on the same system clock
`default_nettype none

interface burst_buf_if;
    import burst_sram_pkg::*;

    logic                      push_valid;
    logic                      push_ready;
    logic [WORDS*DATA_W-1:0]   push_data;
    logic                      pop_valid;
    logic                      pop_ready;
    logic [WORDS*DATA_W-1:0]   pop_data;

    modport fill  (output push_valid, output push_data, input push_ready);
    modport drain (input pop_valid, input pop_data, output pop_ready);
    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
endinterface : burst_buf_if

`default_nettype wire

/* core/burst_buf.sv */
// two-entry flop buffer holding whole read bursts
// assumes clk_sys domain on both sides
`default_nettype none

module burst_buf
    import burst_sram_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  arst_n,
    burst_buf_if.store bus
);
    logic [WORDS*DATA_W-1:0] slot_q [BUF_DEPTH];
    logic                    wr_idx_q;
    logic                    rd_idx_q;
    logic [1:0]              count_q;
    logic                    do_push;
    logic                    do_pop;

    assign bus.push_ready = (count_q != 2'(BUF_DEPTH));
    assign bus.pop_valid  = (count_q != 2'h0);
    assign bus.pop_data   = slot_q[rd_idx_q];
    assign do_push        = bus.push_valid && bus.push_ready;
    assign do_pop         = bus.pop_valid && bus.pop_ready;

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            slot_q[wr_idx_q] <= bus.push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_idx_q <= 1'b0;
            rd_idx_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            wr_idx_q <= wr_idx_q ^ do_push;
            rd_idx_q <= rd_idx_q ^ do_pop;
            count_q  <= count_q + 2'(do_push) - 2'(do_pop);
        end
    end

    chk_buf_depth_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
        count_q <= 2'(BUF_DEPTH))
        else $error("burst buffer holds more than two bursts");

endmodule : burst_buf

`default_nettype wire

/* core/burst_sram_port.sv */
// burst-of-two sram with separate read and write ports, read side in focus
// assumes link clocks and pins are slow enough for clk_sys to see every level
`default_nettype none

module burst_sram_port
    import burst_sram_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              k,
    input  wire logic              k_n,
    input  wire logic              c,
    input  wire logic              c_n,
    input  wire logic              read_port_select_n,
    input  wire logic              write_port_select_n,
    input  wire logic [LANES-1:0]  byte_write_select_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] d,
    input  wire logic              expansion_addr_tie_low_a,
    input  wire logic              expansion_addr_tie_low_b,
    output logic      [DATA_W-1:0] q,
    output logic                   q_oe,
    output logic                   read_stall
);

    function automatic logic rose(input logic now_v, input logic was_v);
        return now_v && !was_v;
    endfunction : rose

    // ---- pin synchroniser: stage one feeds stage two only
    pins_s pins_w;
    pins_s meta_q;
    pins_s sync_q;
    pins_s prev_q;

    assign pins_w = '{k: k, k_n: k_n, c: c, c_n: c_n,
                      rps_n: read_port_select_n, wps_n: write_port_select_n,
                      bws_n: byte_write_select_n, addr: addr, d: d};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= PINS_RESET;
            sync_q <= PINS_RESET;
            prev_q <= PINS_RESET;
        end else begin
            meta_q <= pins_w;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    logic k_rise;
    logic kn_rise;
    assign k_rise  = rose(sync_q.k, prev_q.k);
    assign kn_rise = rose(sync_q.k_n, prev_q.k_n);

    // ---- strap: caught once after release, never re-read
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;
    logic       single_clk_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt_q  <= STRAP_CNT_RESET;
            strap_done_q <= 1'b0;
            single_clk_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'(STRAP_SETTLE_CYC)) begin
                strap_done_q <= 1'b1;
                single_clk_q <= sync_q.c && sync_q.c_n;
            end
        end
    end

    // output edges lag input edges one cycle so a burst due at this edge is buffered
    logic out_pos_q;
    logic out_neg_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_pos_q <= 1'b0;
            out_neg_q <= 1'b0;
        end else begin
            out_pos_q <= strap_done_q && (single_clk_q ? k_rise
                                          : rose(sync_q.c, prev_q.c));
            out_neg_q <= strap_done_q && (single_clk_q ? kn_rise
                                          : rose(sync_q.c_n, prev_q.c_n));
        end
    end

    // ---- storage: word 0 array holds A+0, word 1 array holds A+1
    logic [DATA_W-1:0] mem_q [WORDS][DEPTH];

    // ---- write path
    logic              wr_act_q;
    logic [DATA_W-1:0] wr_lo_q;
    logic [LANES-1:0]  wr_be_lo_q;
    logic              wr_commit;
    logic [DATA_W-1:0] wr_word [WORDS];
    logic [LANES-1:0]  wr_be   [WORDS];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_act_q   <= 1'b0;
            wr_lo_q    <= Q_RESET;
            wr_be_lo_q <= 2'h0;
        end else if (k_rise) begin
            wr_act_q   <= !sync_q.wps_n;
            wr_lo_q    <= sync_q.d;
            wr_be_lo_q <= ~sync_q.bws_n;
        end else if (kn_rise) begin
            wr_act_q <= 1'b0;
        end
    end

    // upper word, its byte selects and the address arrive on the negative rise
    assign wr_commit  = kn_rise && wr_act_q;
    assign wr_word[0] = wr_lo_q;
    assign wr_word[1] = sync_q.d;
    assign wr_be[0]   = wr_be_lo_q;
    assign wr_be[1]   = ~sync_q.bws_n;

    // one process per array: lanes of a word share the addressed element
    for (genvar w = 0; w < WORDS; w++) begin : g_word
        always_ff @(posedge clk_sys) begin
            for (int b = 0; b < LANES; b++) begin
                if (wr_commit && wr_be[w][b]) begin
                    mem_q[w][sync_q.addr][b*LANE_W +: LANE_W] <=
                        wr_word[w][b*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ---- read acceptance; the burst enters the buffer at the next input rise that finds a free slot
    burst_buf_if buf_bus ();

    logic                    rd_pend_q;
    logic [ADDR_W-1:0]       rd_addr_q;
    logic [WORDS*DATA_W-1:0] rd_data_q;
    logic                    rd_take;
    logic                    rd_slot_free;

    assign rd_slot_free       = !rd_pend_q || buf_bus.push_ready;
    assign rd_take            = k_rise && !sync_q.rps_n && rd_slot_free;
    assign buf_bus.push_valid = rd_pend_q && k_rise;
    assign buf_bus.push_data  = rd_data_q;
    assign read_stall         = rd_pend_q && !buf_bus.push_ready;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 18'h0_0000;
            rd_data_q <= 36'h0_0000_0000;
        end else begin
            if (rd_take) begin
                rd_pend_q <= 1'b1;
                rd_addr_q <= sync_q.addr;
                rd_data_q <= {mem_q[1][sync_q.addr], mem_q[0][sync_q.addr]};
            end else if (buf_bus.push_valid && buf_bus.push_ready) begin
                rd_pend_q <= 1'b0;
            end
        end
    end

    burst_buf u_buf (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .bus     (buf_bus.store)
    );

    // ---- output sequencer
    out_state_e        out_state_q;
    logic [DATA_W-1:0] q_q;
    logic [DATA_W-1:0] hi_hold_q;
    logic              q_oe_q;

    assign buf_bus.pop_ready = out_pos_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_state_q <= OUT_IDLE;
            q_q         <= Q_RESET;
            hi_hold_q   <= Q_RESET;
            q_oe_q      <= 1'b0;
        end else if (out_pos_q) begin
            if (buf_bus.pop_valid) begin
                out_state_q <= OUT_LO;
                q_q         <= buf_bus.pop_data[DATA_W-1:0];
                hi_hold_q   <= buf_bus.pop_data[WORDS*DATA_W-1:DATA_W];
                q_oe_q      <= 1'b1;
            end else begin
                out_state_q <= OUT_IDLE;
                q_oe_q      <= 1'b0;
            end
        end else if (out_neg_q) begin
            case (out_state_q)
                OUT_LO: begin
                    out_state_q <= OUT_HI;
                    q_q         <= hi_hold_q;
                end
                default: begin
                    out_state_q <= out_state_q;
                end
            endcase
        end
    end

    assign q    = q_q;
    assign q_oe = q_oe_q;

    // ---- checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_read_addr_latch: assert property (rd_take |=> rd_pend_q &&
        rd_addr_q == $past(sync_q.addr))
        else $error("read address not latched with read select");

    chk_write_lo_capture: assert property (k_rise && !sync_q.wps_n |=>
        wr_act_q && wr_lo_q == $past(sync_q.d) && wr_be_lo_q == ~$past(sync_q.bws_n))
        else $error("lower write word or byte selects not captured");

    chk_lo_word_launch: assert property (out_pos_q && buf_bus.pop_valid |=>
        q_oe_q && q_q == $past(buf_bus.pop_data[DATA_W-1:0]))
        else $error("lower word not driven at positive output rise");

    chk_hi_word_follow: assert property (out_neg_q && !out_pos_q &&
        out_state_q == OUT_LO |=> q_q == $past(hi_hold_q) && q_oe_q)
        else $error("upper word not driven at negative output rise");

    chk_release_idle: assert property (out_pos_q && !buf_bus.pop_valid |=>
        !q_oe_q ##1 !q_oe_q [*1])
        else $error("outputs not released after burst");

    chk_oe_needs_burst: assert property (q_oe_q |-> out_state_q != OUT_IDLE)
        else $error("outputs driven with no burst in flight");

    chk_strap_frozen: assert property (strap_done_q |=> $stable(single_clk_q))
        else $error("clock mode changed during operation");

    chk_pending_kept: assert property (rd_pend_q && !k_rise |=> rd_pend_q)
        else $error("pending read burst dropped");

    chk_read_no_gap: assert property (q_oe_q && out_pos_q &&
        buf_bus.pop_valid |=> q_oe_q)
        else $error("gap inserted between back-to-back bursts");

    cov_back_to_back: cover property (out_pos_q && buf_bus.pop_valid &&
        out_state_q == OUT_HI);
    cov_single_clock: cover property (single_clk_q && q_oe_q);
    cov_write_commit: cover property (wr_commit ##[1:40] rd_take);
    cov_read_stall:   cover property (read_stall);

endmodule : burst_sram_port

`default_nettype wire

/* bench/burst_ctrl_model.sv */
// controller side: link clocks and strap levels for the sram port
// assumes the bench drives the request pins around these clocks
`default_nettype none

module burst_ctrl_model (
    input  wire logic c_run,
    output logic      k,
    output logic      k_n,
    output logic      c,
    output logic      c_n,
    output logic      tie_lo,
    output logic      strap_hi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        k = 1'b0;
        // phase unrelated to clk_sys
        #13.3;
        forever #40 k = ~k;
    end
    assign k_n = ~k;
    // stopped c rests low, c_n high; c_run only moves while k is low
    assign c = k & c_run;
    assign c_n = ~k | ~c_run;
    assign tie_lo = 1'b0;
    assign strap_hi = 1'b1;
endmodule : burst_ctrl_model

`default_nettype wire

/* bench/burst_sram_port_bench.sv */
// self-checking bench of the burst sram read port
// assumes burst_ctrl_model makes the link clocks
`default_nettype none

module burst_sram_port_bench
    import burst_sram_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        int                t;
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
    } burst_s;
    logic              clk_sys, arst_n, c_run, k, k_n, c, c_n, tie_lo, strap_hi;
    logic              read_port_select_n, write_port_select_n;
    logic [LANES-1:0]  byte_write_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d, q, q_sc, r;
    logic              q_oe, q_oe_sc, read_stall, strict, due, lo_seen;
    logic [15:0]       lfsr_q = 16'h59B9;
    logic [DATA_W-1:0] mem [int];
    logic [ADDR_W-1:0] used [8];
    burst_s            exp_q [$];
    int                error_cnt = 0, checks = 0, cycle_cnt = 0, kc = 0;

    burst_ctrl_model ctrl (.c_run, .k, .k_n, .c, .c_n, .tie_lo, .strap_hi);
    burst_sram_port DUT (.clk_sys, .arst_n, .k, .k_n, .c, .c_n, .read_port_select_n,
        .write_port_select_n, .byte_write_select_n, .addr, .d,
        .expansion_addr_tie_low_a(tie_lo), .expansion_addr_tie_low_b(tie_lo),
        .q, .q_oe, .read_stall);
    // second copy strapped for single clock mode
    burst_sram_port DUT_sc (.clk_sys, .arst_n, .k, .k_n, .c(strap_hi), .c_n(strap_hi),
        .read_port_select_n, .write_port_select_n, .byte_write_select_n, .addr, .d,
        .expansion_addr_tie_low_a(tie_lo), .expansion_addr_tie_low_b(tie_lo),
        .q(q_sc), .q_oe(q_oe_sc), .read_stall());

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge k) kc = kc + 1;
    always @(posedge clk_sys) begin
        cycle_cnt = cycle_cnt + 1;
        if (cycle_cnt == 4000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    function automatic logic [DATA_W-1:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return {lfsr_q[3:2], lfsr_q};
    endfunction : rnd
    function automatic void wmerge(input int a, input logic [DATA_W-1:0] v,
                                   input logic [1:0] be);
        if (be[0]) mem[a][8:0] = v[8:0];
        if (be[1]) mem[a][17:9] = v[17:9];
    endfunction : wmerge
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one k period: read and/or write, address muxed across k and k_n
    task automatic op(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                      input logic [ADDR_W-1:0] wa, input logic [1:0] be_lo,
                      input logic [1:0] be_hi);
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
        int                t;
        lo = rnd();
        hi = rnd();
        read_port_select_n = ~rd;
        write_port_select_n = ~wr;
        addr = rd ? ra : rnd();
        d = lo;
        byte_write_select_n = ~be_lo;
        @(posedge k);
        repeat (2) @(posedge clk_sys);
        #1;
        t = kc;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        addr = wr ? wa : rnd();
        d = hi;
        byte_write_select_n = ~be_hi;
        @(posedge k_n);
        repeat (2) @(posedge clk_sys);
        #1;
        // read is fetched at k rise, before this period's write lands at k_n
        if (rd) exp_q.push_back('{t, mem[2 * ra], mem[2 * ra + 1]});
        if (wr) begin
            wmerge(2 * wa, lo, be_lo);
            wmerge(2 * wa + 1, hi, be_hi);
        end
    endtask : op
    task automatic idle(input int n);
        repeat (n) op(1'b0, '0, 1'b0, '0, '0, '0);
    endtask : idle

    // lower word stands across the c_n rise, upper across the c rise
    always @(posedge c_n) begin
        @(posedge clk_sys);
        #1;
        due = exp_q.size() > 0 && exp_q[0].t + 1 == kc;
        if (strict) begin
            chk(DATA_W'(q_oe), DATA_W'(due));
            chk(DATA_W'(q_oe_sc), DATA_W'(due));
        end
        lo_seen = q_oe === 1'b1 && exp_q.size() > 0;
        if (lo_seen) begin
            chk(q, exp_q[0].lo);
            if (strict) chk(q_sc, exp_q[0].lo);
        end
    end
    always @(posedge c) begin
        @(posedge clk_sys);
        #1;
        if (lo_seen) begin
            chk(q, exp_q[0].hi);
            if (strict) chk(q_sc, exp_q[0].hi);
            void'(exp_q.pop_front());
        end
        lo_seen = 1'b0;
    end

    task automatic report_and_stop();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        arst_n = 1'b0;
        c_run = 1'b1;
        strict = 1'b1;
        lo_seen = 1'b0;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        byte_write_select_n = 2'h3;
        addr = 18'h0_0000;
        d = 18'h0_0000;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(DATA_W'(q_oe), 18'h0_0000);
        chk(DATA_W'(read_stall), 18'h0_0000);
        arst_n = 1'b1;
        #80;
        @(posedge clk_sys);
        #1;
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            used[i] = i == 0 ? '0 : i == 7 ? '1 : rnd();
            op(1'b0, '0, 1'b1, used[i], 2'h3, 2'h3);
        end
        // every lane mix on both words, the first eight read back on the second pass
        for (int i = 0; i < 16; i++) begin
            op(1'b1, used[i % 8], 1'b1, used[i % 8], i[1:0], i[3:2]);
        end
        idle(4);
        $display("byte lane test done");
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            op(r[0], used[r[3:1]], r[4], used[r[7:5]], r[9:8], r[11:10]);
        end
        idle(4);
        $display("random mix test done");
        // output clocks stopped: buffer fills, third burst waits
        @(posedge k_n);
        @(posedge clk_sys);
        #1;
        c_run = 1'b0;
        strict = 1'b0;
        for (int i = 0; i < 3; i++) op(1'b1, used[i], 1'b0, '0, '0, '0);
        idle(1);
        chk(DATA_W'(read_stall), 18'h0_0001);
        @(posedge k_n);
        @(posedge clk_sys);
        #1;
        c_run = 1'b1;
        idle(5);
        chk(DATA_W'(exp_q.size()), 18'h0_0000);
        $display("stall test done");
        report_and_stop();
    end
endmodule : burst_sram_port_bench

`default_nettype wire
